// *** verilog/device_port_pkg.sv ***
/*
 * Constants, register map and carrier types of the USB device port
 * status and control block.
 * Assumes a 100 MHz register clock and a serial engine that reports bus
 * events as one-cycle pulses, and bus activity as a level, synchronous to that clock.
 */
package device_port_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SUSPEND_IDLE_MS = 3;
    localparam int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_MS * (CLK_HZ / 1000);

    // Sizes
    localparam int unsigned NUM_ENDPOINTS = 8;
    localparam int unsigned FRAME_W = 11;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned IRQ_W = 14;

    // Register byte addresses
    localparam logic [31:0] FRAME_NUMBER_ADDR = 32'h40084000;
    localparam logic [31:0] GLOBAL_STATE_ADDR = 32'h40084004;
    localparam logic [31:0] FUNCTION_ADDRESS_ADDR = 32'h40084008;
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h40084010;
    localparam logic [31:0] IRQ_DISABLE_ADDR = 32'h40084014;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h40084018;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4008401c;
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h40084020;
    localparam logic [31:0] FRAME_BYTES_ADDR = 32'h40084024;

    // Frame number register fields
    localparam int unsigned FRAME_BAD_BIT = 16;
    localparam int unsigned FRAME_GOOD_BIT = 17;
    // Byte view: good flag in high byte, bad flag in low byte
    localparam int unsigned BYTE_GOOD_BIT = 4;
    localparam int unsigned BYTE_BAD_BIT = 3;

    // Global state register fields
    localparam int unsigned ADDRESS_STATE_BIT = 0;
    localparam int unsigned CONFIGURED_STATE_BIT = 1;
    localparam int unsigned SEND_RESUME_BIT = 2;
    localparam int unsigned REMOTE_WAKE_BIT = 3;

    // Function address register fields
    localparam int unsigned FUNCTION_ENABLE_BIT = 8;

    // Interrupt bit positions; endpoints sit at 0..7
    localparam int unsigned SUSPEND_IRQ_BIT = 8;
    localparam int unsigned RESUME_IRQ_BIT = 9;
    localparam int unsigned FRAME_START_IRQ_BIT = 11;
    localparam int unsigned BUS_RESET_DONE_IRQ_BIT = 12;
    localparam int unsigned WAKEUP_IRQ_BIT = 13;

    // Bits the enable and disable registers may touch
    localparam logic [IRQ_W-1:0] MASKABLE_BITS = 14'h2bff;
    // Bits the clear register may touch
    localparam logic [IRQ_W-1:0] CLEARABLE_BITS = 14'h3b00;
    // Mask after reset: resume enabled, bit 12 fixed
    localparam logic [IRQ_W-1:0] MASK_RESET = 14'h1200;
    localparam logic [IRQ_W-1:0] FIXED_MASK = 14'h1000;

    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Per-endpoint flags from the endpoint status registers
    typedef struct packed {
        logic setup_received;
        logic bank0_received;
        logic bank1_received;
        logic in_done;
        logic stall_acked;
    } ep_flags_s;

    // Bus events from the serial engine
    typedef struct packed {
        logic sof_pid;
        logic sof_eop;
        logic sof_error;
        logic [FRAME_W-1:0] sof_frame;
        logic bus_activity;
        logic resume_seen;
        logic bus_reset_done;
    } bus_events_s;

    // Device state as seen by the serial engine
    typedef struct packed {
        logic address_state;
        logic configured_state;
        logic function_enable;
        logic [FADDR_W-1:0] function_addr_value;
    } dev_state_s;

endpackage

// *** verilog/endpoint_irq_merge.sv ***
/*
 * Merges the five status flags of every endpoint into one interrupt
 * status bit per endpoint.
 * Assumes the flags are levels held in the endpoint registers until
 * software clears them there.
 */
`timescale 1ns/1ps
`default_nettype none
module endpoint_irq_merge #(
    parameter int unsigned EPS = device_port_pkg::NUM_ENDPOINTS
) (
    input wire device_port_pkg::ep_flags_s [EPS-1:0] flags,
    output logic [EPS-1:0] ep_irq
);
    import device_port_pkg::*;

    // The bit holds as long as any flag holds, so it is sticky by nature
    genvar i;
    generate
        for (i = 0; i < EPS; i++) begin : g_ep
            assign ep_irq[i] = |flags[i];
        end
    endgenerate
endmodule
`default_nettype wire

// *** verilog/bus_idle_timer.sv ***
/*
 * Counts cycles without bus activity and reports suspend.
 * Assumes bus_activity is a level synchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_idle_timer #(
    parameter int unsigned IDLE_CYCLES = device_port_pkg::SUSPEND_IDLE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bus_activity,
    output logic suspend_event,
    output logic suspended
);
    import device_port_pkg::*;

    localparam int unsigned CW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

    logic [CW-1:0] idle_count;

    // Idle counter restarts on any activity and stops once suspended
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_count <= '0;
        end else if (bus_activity || suspended) begin
            idle_count <= '0;
        end else begin
            idle_count <= idle_count + 1'b1;
        end
    end

    // One event per idle period; activity leaves suspend
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            suspend_event <= 1'b0;
            suspended <= 1'b0;
        end else begin
            suspend_event <= !bus_activity && !suspended && idle_count == LAST;
            if (bus_activity) begin
                suspended <= 1'b0;
            end else if (idle_count == LAST) begin
                suspended <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/device_port_regs.sv ***
/*
 * Register-side control and status of a full-speed USB device port:
 * frame number, device state, function address, remote wakeup trigger
 * and the interrupt enable, disable, mask, status and clear registers.
 * Assumes an AHB-Lite master on hclk, a serial engine that reports bus
 * events synchronously, and endpoint registers that hold their flags.
 */
// Register access over AHB-Lite was left to the implementer.
// What this block does
// - Latch frame number at each SOF end
// - Set bad or good flag; clear on PID
// - SOF status rises on PID, not EOP
// - Byte view: good bit 4, bad bit 3
// - Address state set by 1, reset only
// - Configured bit written and read directly
// - Wakeup starts on send-resume rise with enable
// - Seven-bit function address, zero after reset
// - Endpoints work only with function enable
// - Enable register sets mask bits
// - Disable register clears mask; mask reads back
// - Mask bit 12 always reads one
// - Resume mask resets to enabled
// - Endpoint status is OR of its flags
// - Suspend status after 3 ms idle
// - Resume status on resume at port
// - SOF status on every SOF token
// - Bus reset done status at reset end
// - Wakeup status on host resume or reset
// - Clear register clears event status bits
// - Bus reset done status is unmaskable
// - Bus reset end restores mask, endpoint registers
`timescale 1ns/1ps
`default_nettype none
module device_port_regs #(
    parameter int unsigned IDLE_CYCLES = device_port_pkg::SUSPEND_IDLE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial engine side
    input wire device_port_pkg::bus_events_s bus_events,
    input wire device_port_pkg::ep_flags_s [device_port_pkg::NUM_ENDPOINTS-1:0] ep_flags,
    output device_port_pkg::dev_state_s dev_state,
    output logic endpoints_active,
    output logic remote_wake_start,
    output logic suspended,
    output logic ep_regs_reset,
    output logic irq
);
    import device_port_pkg::*;

    // Bus pipeline
    logic dphase_write;
    logic dphase_read;
    logic [31:0] dphase_addr;
    logic read_wait;
    // Frame tracking
    logic [FRAME_W-1:0] frame_count;
    logic frame_bad;
    logic frame_good;
    // Device state
    logic address_state;
    logic configured_state;
    logic send_resume;
    logic remote_wake_enable;
    logic [FADDR_W-1:0] function_addr_value;
    logic function_enable;
    // Interrupts
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_sticky;
    logic [IRQ_W-1:0] irq_status;
    logic [NUM_ENDPOINTS-1:0] ep_irq;
    logic suspend_event;
    // Write strobes decoded in the data phase
    logic wr_global;
    logic wr_faddr;
    logic wr_enable;
    logic wr_disable;
    logic wr_clear;
    logic [IRQ_W-1:0] hw_set;
    logic [IRQ_W-1:0] sw_clear;
    logic [IRQ_W-1:0] next_mask;
    logic [31:0] next_rdata;

    // True for a write data phase aimed at the given register
    function automatic logic hits(input logic [31:0] a, input logic [31:0] reg_addr, input logic w);
        return w && a == reg_addr;
    endfunction

    // Endpoint flags merge into one bit each
    endpoint_irq_merge #(
        .EPS(NUM_ENDPOINTS)
    ) u_ep_merge (
        .flags(ep_flags),
        .ep_irq(ep_irq)
    );

    // Bus idle detection for suspend
    bus_idle_timer #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_idle (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus_activity(bus_events.bus_activity),
        .suspend_event(suspend_event),
        .suspended(suspended)
    );

    // Address phase capture; reads get one wait state so a write just
    // before them is already visible in the returned word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_write <= 1'b0;
            dphase_read <= 1'b0;
            dphase_addr <= '0;
        end else if (hready) begin
            dphase_write <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            dphase_read <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
            dphase_addr <= haddr;
        end
    end

    // Wait-state flag for read data phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_wait <= 1'b0;
        end else begin
            read_wait <= dphase_read && !read_wait;
        end
    end

    // Only word transfers are expected; hsize is not checked
    assign hreadyout = !(dphase_read && !read_wait);
    assign hresp = 1'b0;

    // Data phase write strobes
    assign wr_global = hits(dphase_addr, GLOBAL_STATE_ADDR, dphase_write);
    assign wr_faddr = hits(dphase_addr, FUNCTION_ADDRESS_ADDR, dphase_write);
    assign wr_enable = hits(dphase_addr, IRQ_ENABLE_ADDR, dphase_write);
    assign wr_disable = hits(dphase_addr, IRQ_DISABLE_ADDR, dphase_write);
    assign wr_clear = hits(dphase_addr, IRQ_CLEAR_ADDR, dphase_write);

    // Frame number and quality flags from SOF packets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_count <= '0;
            frame_bad <= 1'b0;
            frame_good <= 1'b0;
        end else if (bus_events.sof_eop) begin
            frame_count <= bus_events.sof_frame;
            frame_bad <= bus_events.sof_error;
            frame_good <= !bus_events.sof_error;
        end else if (bus_events.sof_pid) begin
            frame_bad <= 1'b0;
            frame_good <= 1'b0;
        end
    end

    // Address state: a write of 1 enters it, only reset leaves it.
    // Software is trusted to have loaded the address and finished the
    // status stage first; nothing here checks that order.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            address_state <= 1'b0;
        end else if (wr_global && hwdata[ADDRESS_STATE_BIT]) begin
            address_state <= 1'b1;
        end
    end

    // Configured state, send-resume and remote wake enable are plain bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            configured_state <= 1'b0;
            send_resume <= 1'b0;
            remote_wake_enable <= 1'b0;
        end else if (wr_global) begin
            configured_state <= hwdata[CONFIGURED_STATE_BIT];
            send_resume <= hwdata[SEND_RESUME_BIT];
            remote_wake_enable <= hwdata[REMOTE_WAKE_BIT];
        end
    end

    // Wakeup starts only on a 0 to 1 step of send-resume; rewriting 1
    // does nothing, so software must write 0 between procedures
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_wake_start <= 1'b0;
        end else begin
            remote_wake_start <= wr_global && hwdata[SEND_RESUME_BIT] && !send_resume
                && hwdata[REMOTE_WAKE_BIT];
        end
    end

    // Function address and function enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            function_addr_value <= '0;
            function_enable <= 1'b0;
        end else if (wr_faddr) begin
            function_addr_value <= hwdata[FADDR_W-1:0];
            function_enable <= hwdata[FUNCTION_ENABLE_BIT];
        end
    end

    assign dev_state.address_state = address_state;
    assign dev_state.configured_state = configured_state;
    assign dev_state.function_enable = function_enable;
    assign dev_state.function_addr_value = function_addr_value;
    // Endpoint traffic gate for the serial engine
    assign endpoints_active = function_enable;

    // Mask update: bus reset end restores the reset value, otherwise
    // enable sets and disable clears the writable bits
    always_comb begin
        next_mask = irq_mask;
        if (bus_events.bus_reset_done) begin
            next_mask = MASK_RESET;
        end else if (wr_enable) begin
            next_mask = irq_mask | (hwdata[IRQ_W-1:0] & MASKABLE_BITS);
        end else if (wr_disable) begin
            next_mask = irq_mask & ~(hwdata[IRQ_W-1:0] & MASKABLE_BITS);
        end
        next_mask = next_mask | FIXED_MASK;
    end

    // Mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= MASK_RESET;
        end else begin
            irq_mask <= next_mask;
        end
    end

    // Endpoint registers are reset together with the mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ep_regs_reset <= 1'b0;
        end else begin
            ep_regs_reset <= bus_events.bus_reset_done;
        end
    end

    // Hardware events that set sticky status bits
    always_comb begin
        hw_set = '0;
        hw_set[SUSPEND_IRQ_BIT] = suspend_event;
        hw_set[RESUME_IRQ_BIT] = bus_events.resume_seen;
        hw_set[FRAME_START_IRQ_BIT] = bus_events.sof_pid;
        hw_set[BUS_RESET_DONE_IRQ_BIT] = bus_events.bus_reset_done;
        hw_set[WAKEUP_IRQ_BIT] = bus_events.resume_seen || bus_events.bus_reset_done;
    end

    assign sw_clear = wr_clear ? (hwdata[IRQ_W-1:0] & CLEARABLE_BITS) : '0;

    // Sticky event bits; a set in the same cycle as its clear wins, so
    // no event is lost. Cleared at reset for a known start even though
    // software is still expected to clear resume and wakeup.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_sticky <= '0;
        end else begin
            irq_sticky <= (irq_sticky & ~sw_clear) | (hw_set & CLEARABLE_BITS);
        end
    end

    // Endpoint bits follow their flags, the rest are sticky
    assign irq_status = {irq_sticky[IRQ_W-1:NUM_ENDPOINTS], ep_irq};

    // Single interrupt output; bus reset done bypasses the mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask) || irq_status[BUS_RESET_DONE_IRQ_BIT];
        end
    end

    // Read multiplexer; unmapped and write-only addresses read as zero
    always_comb begin
        next_rdata = '0;
        case (dphase_addr)
            FRAME_NUMBER_ADDR: begin
                next_rdata[FRAME_W-1:0] = frame_count;
                next_rdata[FRAME_BAD_BIT] = frame_bad;
                next_rdata[FRAME_GOOD_BIT] = frame_good;
            end
            FRAME_BYTES_ADDR: begin
                // Byte-wide view: low byte in [7:0], high byte in [15:8]
                next_rdata[7:0] = frame_count[7:0];
                next_rdata[BYTE_BAD_BIT] = frame_bad;
                next_rdata[10:8] = frame_count[FRAME_W-1:8];
                next_rdata[8 + BYTE_GOOD_BIT] = frame_good;
            end
            GLOBAL_STATE_ADDR: begin
                next_rdata[ADDRESS_STATE_BIT] = address_state;
                next_rdata[CONFIGURED_STATE_BIT] = configured_state;
                next_rdata[SEND_RESUME_BIT] = send_resume;
                next_rdata[REMOTE_WAKE_BIT] = remote_wake_enable;
            end
            FUNCTION_ADDRESS_ADDR: begin
                next_rdata[FADDR_W-1:0] = function_addr_value;
                next_rdata[FUNCTION_ENABLE_BIT] = function_enable;
            end
            IRQ_MASK_ADDR: begin
                next_rdata[IRQ_W-1:0] = irq_mask;
            end
            IRQ_STATUS_ADDR: begin
                next_rdata[IRQ_W-1:0] = irq_status;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Read data is loaded during the wait state and held after it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (dphase_read && !read_wait) begin
            hrdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// *** testbench/device_port_checker_assertions.sv ***
/* Checker of the port register block.
   Watches top-level ports only. */
`timescale 1ns/1ps
`default_nettype none
module device_port_checker
import device_port_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire device_port_pkg::bus_events_s bus_events,
    input wire device_port_pkg::dev_state_s dev_state,
    input wire logic endpoints_active,
    input wire logic remote_wake_start,
    input wire logic suspended,
    input wire logic ep_regs_reset,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A read data phase waits exactly one cycle
    a_read_one_wait: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait");
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp");
    // Unmaskable bus reset end
    a_busrst_irq: assert property (bus_events.bus_reset_done |-> ##2 irq)
        else $error("busrst irq");
    a_eprst_follow: assert property (bus_events.bus_reset_done |=> ep_regs_reset)
        else $error("ep reset late");
    a_eprst_cause: assert property (ep_regs_reset |-> $past(bus_events.bus_reset_done))
        else $error("ep reset cause");
    a_fen_active: assert property (endpoints_active == dev_state.function_enable)
        else $error("fen gate");
    a_wake_single: assert property (remote_wake_start |=> !remote_wake_start)
        else $error("wake width");
    a_addr_sticky: assert property (dev_state.address_state |=> dev_state.address_state)
        else $error("addr state");
    a_susp_leave: assert property (bus_events.bus_activity |=> !suspended)
        else $error("suspend exit");

    c_sof: cover property (bus_events.sof_pid);
    c_wake: cover property (remote_wake_start);
    c_susp: cover property ($rose(suspended));
endmodule

bind device_port_regs device_port_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .bus_events,
    .dev_state, .endpoints_active, .remote_wake_start, .suspended, .ep_regs_reset, .irq
);
`default_nettype wire

// *** testbench/usb_host_model.sv ***
/* Host side as the serial engine reports it.
   Tasks are called from the bench. */
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    input wire logic hclk,
    output var device_port_pkg::bus_events_s bus_events,
    output var device_port_pkg::ep_flags_s [device_port_pkg::NUM_ENDPOINTS-1:0] ep_flags
);
    import device_port_pkg::*;

    // Quiet, active bus at time zero; the register clock never stops
    initial begin
        bus_events = '0;
        bus_events.bus_activity = 1'b1;
        ep_flags = '0;
    end

    // One-cycle event: 0 packet id, 1 resume, 2 bus reset end
    task automatic pulse(input int k);
        @(posedge hclk);
        case (k)
            0: bus_events.sof_pid <= 1'b1;
            1: bus_events.resume_seen <= 1'b1;
            default: bus_events.bus_reset_done <= 1'b1;
        endcase
        @(posedge hclk);
        bus_events.sof_pid <= 1'b0;
        bus_events.resume_seen <= 1'b0;
        bus_events.bus_reset_done <= 1'b0;
    endtask

    // Frame fields valid only with the end pulse; scrambled after it
    task automatic sof_end(input logic [10:0] f, input logic e);
        @(posedge hclk);
        bus_events.sof_eop <= 1'b1;
        bus_events.sof_error <= e;
        bus_events.sof_frame <= f;
        @(posedge hclk);
        bus_events.sof_eop <= 1'b0;
        bus_events.sof_error <= ~e;
        bus_events.sof_frame <= ~f;
    endtask

    task automatic act(input logic v);
        @(posedge hclk);
        bus_events.bus_activity <= v;
    endtask

    task automatic set_ep(input int n, input ep_flags_s v);
        @(posedge hclk);
        ep_flags[n] <= v;
    endtask
endmodule
`default_nettype wire

// *** testbench/device_port_regs_tb.sv ***
/* Self-checking bench of the port register block.
   Assumes a 100 MHz clock and the host model. */
`timescale 1ns/1ps
`default_nettype none
module device_port_regs_tb;
    import device_port_pkg::*;
    localparam int unsigned IDLE = 20;
    localparam int LIMIT = 20000;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, rdy, hresp, endpoints_active, remote_wake_start, suspended, ep_regs_reset, irq;
    logic [31:0] hrdata;
    bus_events_s bus_events;
    ep_flags_s [NUM_ENDPOINTS-1:0] ep_flags;
    dev_state_s dev_state;
    int fail_count = 0, checks = 0, cycles = 0, wakes = 0;

    device_port_regs #(.IDLE_CYCLES(IDLE)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .bus_events, .ep_flags, .dev_state, .endpoints_active,
        .remote_wake_start, .suspended, .ep_regs_reset, .irq
    );
    usb_host_model host (.hclk, .bus_events, .ep_flags);

    always #5 hclk = ~hclk;

    // Ready as it stands at the coming edge, free of the edge race
    always @(negedge hclk) rdy <= hreadyout;

    // Watchdog and count of wake pulses
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (remote_wake_start === 1'b1) begin
            wakes <= wakes + 1;
        end
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One word transfer; each phase held to an edge with ready high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(name, exp, r);
    endtask

    task automatic t_reset();
        rd("mask", IRQ_MASK_ADDR, 32'h1200);
        rd("faddr", FUNCTION_ADDRESS_ADDR, 32'h0);
        rd("state", GLOBAL_STATE_ADDR, 32'h0);
        wr(IRQ_CLEAR_ADDR, 32'h3b00);
        rd("wo_read", IRQ_ENABLE_ADDR, 32'h0);
        rd("unmapped", 32'h4008400c, 32'h0);
    endtask

    task automatic t_mask();
        wr(IRQ_ENABLE_ADDR, 32'h3fff);
        rd("mask_en", IRQ_MASK_ADDR, 32'h3bff);
        wr(IRQ_DISABLE_ADDR, 32'h0);
        rd("mask_nop", IRQ_MASK_ADDR, 32'h3bff);
        wr(IRQ_DISABLE_ADDR, 32'h3fff);
        rd("mask_dis", IRQ_MASK_ADDR, 32'h1000);
    endtask

    // Good then bad frame; bad flag replaces low byte bit 3
    task automatic t_sof();
        wr(IRQ_CLEAR_ADDR, 32'h3b00);
        host.pulse(0);
        rd("sof_pid", IRQ_STATUS_ADDR, 32'h0800);
        host.sof_end(11'h5ad, 1'b0);
        rd("frame", FRAME_NUMBER_ADDR, 32'h205ad);
        rd("bytes", FRAME_BYTES_ADDR, 32'h15a5);
        host.pulse(0);
        rd("flags_off", FRAME_NUMBER_ADDR, 32'h5ad);
        host.sof_end(11'h7f7, 1'b1);
        rd("frame_bad", FRAME_NUMBER_ADDR, 32'h107f7);
        rd("bytes_bad", FRAME_BYTES_ADDR, 32'h07ff);
        wr(IRQ_CLEAR_ADDR, 32'h0800);
        rd("sof_clr", IRQ_STATUS_ADDR, 32'h0);
    endtask

    task automatic t_events();
        host.pulse(1);
        rd("resume", IRQ_STATUS_ADDR, 32'h2200);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(IRQ_ENABLE_ADDR, 32'h2000);
        repeat (2) @(posedge hclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        host.pulse(2);
        rd("busrst", IRQ_STATUS_ADDR, 32'h3200);
        rd("mask_rst", IRQ_MASK_ADDR, 32'h1200);
        wr(IRQ_CLEAR_ADDR, 32'h2200);
        rd("left", IRQ_STATUS_ADDR, 32'h1000);
        chk("irq_fixed", 32'h1, {31'h0, irq});
        wr(IRQ_CLEAR_ADDR, 32'h1000);
        repeat (2) @(posedge hclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd("none", IRQ_STATUS_ADDR, 32'h0);
    endtask

    // Address loaded before address state
    task automatic t_state();
        wr(FUNCTION_ADDRESS_ADDR, 32'h17f);
        rd("faddr_rw", FUNCTION_ADDRESS_ADDR, 32'h17f);
        chk("active", 32'h1, {31'h0, endpoints_active});
        wr(GLOBAL_STATE_ADDR, 32'h1);
        wr(GLOBAL_STATE_ADDR, 32'h0);
        rd("addr_state", GLOBAL_STATE_ADDR, 32'h1);
        wr(GLOBAL_STATE_ADDR, 32'h2);
        rd("config_on", GLOBAL_STATE_ADDR, 32'h3);
        wr(GLOBAL_STATE_ADDR, 32'h4);
        wr(GLOBAL_STATE_ADDR, 32'h0);
        wr(GLOBAL_STATE_ADDR, 32'h8);
        wr(GLOBAL_STATE_ADDR, 32'hc);
        wr(GLOBAL_STATE_ADDR, 32'hc);
        repeat (2) @(posedge hclk);
        chk("wakes", 32'h1, 32'(wakes));
        rd("config_off", GLOBAL_STATE_ADDR, 32'hd);
    endtask

    // Each endpoint with one flag; every flag kind used at least once
    task automatic t_ep();
        wr(IRQ_ENABLE_ADDR, 32'hff);
        for (int i = 0; i < 8; i++) begin
            host.set_ep(i, ep_flags_s'(5'h1 << (i % 5)));
            rd("ep_stat", IRQ_STATUS_ADDR, 32'h1 << i);
            chk("ep_irq", 32'h1, {31'h0, irq});
            host.set_ep(i, '0);
        end
        rd("ep_none", IRQ_STATUS_ADDR, 32'h0);
    endtask

    task automatic t_suspend();
        host.act(1'b0);
        repeat (IDLE + 5) @(posedge hclk);
        chk("suspended", 32'h1, {31'h0, suspended});
        rd("susp_stat", IRQ_STATUS_ADDR, 32'h0100);
        host.act(1'b1);
        repeat (2) @(posedge hclk);
        chk("awake", 32'h0, {31'h0, suspended});
    endtask

    task automatic end_sim();
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset, then each scenario
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_mask();
        t_sof();
        t_events();
        t_state();
        t_ep();
        t_suspend();
        end_sim();
    end
endmodule
`default_nettype wire
